// ### core/pfmc_pkg.sv
// Constants, command codes and operation codes for the parallel flash host controller.
// Assumes a 50 MHz core clock and a byte-wide asynchronous NOR flash on the far side.
package pfmc_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_LOW_NS = 500;
	localparam int RESET_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_REC_NS = 100;
	localparam int RESET_REC_CYCLES = (RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_NS = 100;
	localparam int ACCESS_CYCLES = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS = 60;
	localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;
	// ****************************************
	// Bus widths
	// ****************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	// ****************************************
	// Command addresses and data
	// ****************************************
	localparam logic [17:0] UNLOCK1_ADDR = 18'h00555;
	localparam logic [17:0] UNLOCK2_ADDR = 18'h00AAA;
	localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_READ_RESET = 8'hF0;
	localparam logic [7:0] CMD_IDENTIFY = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [17:0] SECTOR_MASK = 18'h3E000;
	// ****************************************
	// Host operations
	// ****************************************
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET_CMD = 4'h1,
		OP_RESET_UNLOCK = 4'h2,
		OP_ID_ENTER = 4'h3,
		OP_PROGRAM = 4'h4,
		OP_CHIP_ERASE = 4'h5,
		OP_SECTOR_ERASE = 4'h6,
		OP_SUSPEND = 4'h7,
		OP_RESUME = 4'h8,
		OP_HW_RESET = 4'h9,
		OP_HW_ID_READ = 4'hA
	} pfmc_op_t;
endpackage

// ### core/pfmc_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins.
// Assumes start_i is a one-cycle pulse given only while the cycle engine is idle.
`timescale 1ns/1ns
module pfmc_bus_cycle
	import pfmc_pkg::*;
#(
	parameter int ACC_CYCLES = ACCESS_CYCLES,
	parameter int STB_CYCLES = STROBE_CYCLES
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Cycle request
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic done_o,
	output logic [DATA_W-1:0] rdata_o,
	// Flash pins
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe_o,
	input wire logic [DATA_W-1:0] data_i
);
	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_SETUP = 2'b01,
		B_STROBE = 2'b10,
		B_RELEASE = 2'b11
	} pfmc_bus_st_t;

	localparam logic [7:0] STB_LAST = 8'(STB_CYCLES - 1);
	localparam logic [7:0] RD_LAST = 8'(ACC_CYCLES + SYNC_STAGES - 1);

	pfmc_bus_st_t st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, doe_q, doe_d, done_q, done_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d, sync1_q, sync2_q;

	// ****************************************
	// Cycle sequencing
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		ce_n_d = ce_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		doe_d = doe_q;
		addr_d = addr_q;
		dout_d = dout_q;
		rdata_d = rdata_q;
		done_d = 1'b0;
		case (st_q)
			B_IDLE:
			begin
				if (start_i)
				begin
					wr_d = write_i;
					addr_d = addr_i;
					dout_d = wdata_i;
					ce_n_d = 1'b0;
					oe_n_d = write_i;
					doe_d = write_i;
					cnt_d = 8'h00;
					st_d = B_SETUP;
				end
			end
			B_SETUP:
			begin
				// Write enable falls last so the address is taken on its edge
				we_n_d = !wr_q;
				st_d = B_STROBE;
			end
			B_STROBE:
			begin
				cnt_d = cnt_q + 8'h01;
				if ((wr_q && cnt_q == STB_LAST) || (!wr_q && cnt_q == RD_LAST))
				begin
					we_n_d = 1'b1;
					oe_n_d = 1'b1;
					if (!wr_q)
					begin
						rdata_d = sync2_q;
						ce_n_d = 1'b1;
					end
					st_d = B_RELEASE;
				end
			end
			B_RELEASE:
			begin
				ce_n_d = 1'b1;
				doe_d = 1'b0;
				done_d = 1'b1;
				st_d = B_IDLE;
			end
			default:
			begin
				st_d = B_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		sync1_q <= data_i;
		sync2_q <= sync1_q;
		if (rst_i)
		begin
			st_q <= B_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			doe_q <= 1'b0;
			addr_q <= '0;
			dout_q <= '0;
			rdata_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			ce_n_q <= ce_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			doe_q <= doe_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			rdata_q <= rdata_d;
			done_q <= done_d;
		end
	end

	assign ce_n_o = ce_n_q;
	assign oe_n_o = oe_n_q;
	assign we_n_o = we_n_q;
	assign addr_o = addr_q;
	assign data_o = dout_q;
	assign data_oe_o = doe_q;
	assign done_o = done_q;
	assign rdata_o = rdata_q;

	// ****************************************
	// Checks
	// ****************************************
	no_contention_a: assert property (@(posedge clk_i) disable iff (rst_i) !oe_n_q |-> !doe_q)
		else $error("data driven while output gate low");
	write_shape_a: assert property (@(posedge clk_i) disable iff (rst_i) !we_n_q |-> (!ce_n_q && oe_n_q && doe_q))
		else $error("write strobe low outside a proper write");
	data_latch_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) $rose(we_n_q) |-> !ce_n_q && doe_q)
		else $error("write strobe did not rise first");
	read_shape_a: assert property (@(posedge clk_i) disable iff (rst_i) !oe_n_q |-> (we_n_q && !ce_n_q))
		else $error("output gate low outside a proper read");
	idle_standby_a: assert property (@(posedge clk_i) disable iff (rst_i) (st_q == B_IDLE) |-> ce_n_q)
		else $error("chip select low while idle");
endmodule

// ### core/pfmc_host.sv
// Host controller that drives a byte-wide parallel NOR flash through its pins.
// Assumes pin-level high-voltage switches on address line nine and on reset, enabled by the HV outputs.
// Summary of operation
// - Hold the flash reset pin low at least 500 ns; device returns to read.
// - High voltage on address line nine gives identifier bytes by address bits 0, 8.
// - Write with select and strobe low, gate high; address at later fall, data earlier rise.
// - Multi-cycle commands start AAh to 555h, 55h to AAAh, then command to 555h.
// - F0h anywhere, or after unlock to 555h, returns to array read.
// - Program is unlock pair, A0h to 555h, then the byte to its location.
// - Chip erase is unlock, 80h, unlock, 10h, all command writes to 555h.
// - Sector erase ends with 30h to an address inside the sector, bits 17 to 13.
// - B0h to any address suspends sector erase; 30h resumes it.
`timescale 1ns/1ns
module pfmc_host
	import pfmc_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Command port
	input wire logic CMD_VALID_I,
	input wire pfmc_op_t CMD_OP_I,
	input wire logic [ADDR_W-1:0] CMD_ADDR_I,
	input wire logic [DATA_W-1:0] CMD_DATA_I,
	output logic CMD_READY_O,
	input wire logic OP_DONE_I,
	input wire logic TEMP_UNPROTECT_I,
	// Answer port
	output logic RESP_VALID_O,
	output logic [DATA_W-1:0] RESP_DATA_O,
	output logic RESP_ID_O,
	output logic RESP_PARITY_ERR_O,
	output logic OP_PENDING_O,
	// Flash pins
	output logic FLASH_CE_N_O,
	output logic FLASH_OE_N_O,
	output logic FLASH_WE_N_O,
	output logic FLASH_RESET_N_O,
	output logic [ADDR_W-1:0] FLASH_ADDR_O,
	output logic [DATA_W-1:0] FLASH_DATA_O,
	output logic FLASH_DATA_OE_O,
	input wire logic [DATA_W-1:0] FLASH_DATA_I,
	output logic HV_ADDRESS_LINE_NINE_EN_O,
	output logic HV_RESET_EN_O
);
	typedef enum logic [2:0] {
		S_RST_LOW = 3'b000,
		S_RST_REC = 3'b001,
		S_IDLE = 3'b010,
		S_ISSUE = 3'b011,
		S_WAIT = 3'b100
	} pfmc_st_t;

	localparam logic [7:0] RST_LAST = 8'(RESET_CYCLES - 1);
	localparam logic [7:0] REC_LAST = 8'(RESET_REC_CYCLES - 1);
	// Address bit that turns an identifier read into a protection status read
	localparam int PROT_SEL_BIT = 1;

	pfmc_st_t st_q, st_d;
	pfmc_op_t op_q, op_d, sv_op_q, sv_op_d;
	logic [ADDR_W-1:0] addr_q, addr_d, sv_addr_q, sv_addr_d, b_addr_q, b_addr_d;
	logic [DATA_W-1:0] data_q, data_d, sv_data_q, sv_data_d, b_wdata_q, b_wdata_d;
	logic [DATA_W-1:0] rsp_data_q, rsp_data_d, b_rdata;
	logic [7:0] cnt_q, cnt_d;
	logic [2:0] idx_q, idx_d;
	logic wr_done_q, wr_done_d, last_q, last_d, b_start_q, b_start_d, b_write_q, b_write_d, b_done;
	logic rst_n_q, rst_n_d, hv_line_nine_q, hv_line_nine_d, hv_rst_q, hv_rst_d, id_mode_q, id_mode_d;
	logic active_q, active_d, replay_q, replay_d, ready_q, ready_d;
	logic rsp_v_q, rsp_v_d, rsp_id_q, rsp_id_d, rsp_perr_q, rsp_perr_d;
	logic [26:0] word;

	// ****************************************
	// Command step table
	// ****************************************
	function automatic logic [26:0] step_word(input pfmc_op_t op, input logic [2:0] idx,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [ADDR_W-1:0] wa;
		logic [DATA_W-1:0] sd;
		logic last;
		wa = UNLOCK1_ADDR;
		sd = UNLOCK1_DATA;
		last = 1'b0;
		case (op)
			OP_RESET_CMD:
			begin
				wa = a;
				sd = CMD_READ_RESET;
				last = 1'b1;
			end
			OP_SUSPEND, OP_RESUME:
			begin
				wa = a;
				sd = (op == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
				last = 1'b1;
			end
			default:
			begin
				case (idx)
					3'h1, 3'h4:
					begin
						wa = UNLOCK2_ADDR;
						sd = UNLOCK2_DATA;
					end
					3'h2:
					begin
						case (op)
							OP_RESET_UNLOCK: sd = CMD_READ_RESET;
							OP_ID_ENTER: sd = CMD_IDENTIFY;
							OP_PROGRAM: sd = CMD_PROGRAM;
							default: sd = CMD_ERASE_SETUP;
						endcase
						last = (op == OP_RESET_UNLOCK) || (op == OP_ID_ENTER);
					end
					3'h3:
					begin
						if (op == OP_PROGRAM)
						begin
							wa = a;
							sd = d;
							last = 1'b1;
						end
					end
					3'h5:
					begin
						// Exact command bytes keep the device from aborting back to read
						wa = (op == OP_SECTOR_ERASE) ? (a & SECTOR_MASK) : UNLOCK1_ADDR;
						sd = (op == OP_SECTOR_ERASE) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
						last = 1'b1;
					end
					default:
					begin
						wa = UNLOCK1_ADDR;
					end
				endcase
			end
		endcase
		return {last, wa, sd};
	endfunction

	assign word = step_word(op_q, idx_q, addr_q, data_q);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		data_d = data_q;
		sv_op_d = sv_op_q;
		sv_addr_d = sv_addr_q;
		sv_data_d = sv_data_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		wr_done_d = wr_done_q;
		last_d = last_q;
		b_start_d = 1'b0;
		b_write_d = b_write_q;
		b_addr_d = b_addr_q;
		b_wdata_d = b_wdata_q;
		rst_n_d = rst_n_q;
		hv_line_nine_d = hv_line_nine_q;
		id_mode_d = id_mode_q;
		active_d = active_q && !OP_DONE_I;
		replay_d = replay_q;
		rsp_v_d = 1'b0;
		rsp_data_d = rsp_data_q;
		rsp_id_d = rsp_id_q;
		rsp_perr_d = rsp_perr_q;
		case (st_q)
			S_RST_LOW:
			begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == RST_LAST)
				begin
					rst_n_d = 1'b1;
					cnt_d = 8'h00;
					st_d = S_RST_REC;
				end
			end
			S_RST_REC:
			begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == REC_LAST)
				begin
					st_d = S_IDLE;
					if (replay_q)
					begin
						// Interrupted program or erase left corrupt data, so run it again
						op_d = sv_op_q;
						addr_d = sv_addr_q;
						data_d = sv_data_q;
						idx_d = 3'h0;
						wr_done_d = 1'b0;
						replay_d = 1'b0;
						st_d = S_ISSUE;
					end
				end
			end
			S_IDLE:
			begin
				if (CMD_VALID_I && ready_q)
				begin
					op_d = CMD_OP_I;
					addr_d = CMD_ADDR_I;
					data_d = CMD_DATA_I;
					idx_d = 3'h0;
					wr_done_d = (CMD_OP_I == OP_READ) || (CMD_OP_I == OP_HW_ID_READ);
					st_d = S_ISSUE;
					if (CMD_OP_I == OP_HW_ID_READ)
					begin
						hv_line_nine_d = 1'b1;
					end
					if (CMD_OP_I == OP_HW_RESET)
					begin
						rst_n_d = 1'b0;
						id_mode_d = 1'b0;
						replay_d = active_q && !OP_DONE_I;
						active_d = 1'b0;
						cnt_d = 8'h00;
						st_d = S_RST_LOW;
						rsp_v_d = 1'b1;
						rsp_data_d = 8'h00;
						rsp_id_d = 1'b0;
						rsp_perr_d = 1'b0;
					end
				end
			end
			S_ISSUE:
			begin
				b_start_d = 1'b1;
				b_write_d = !wr_done_q;
				b_addr_d = wr_done_q ? addr_q : word[25:8];
				b_wdata_d = word[7:0];
				last_d = word[26];
				st_d = S_WAIT;
			end
			S_WAIT:
			begin
				if (b_done)
				begin
					if (b_write_q && !last_q)
					begin
						idx_d = idx_q + 3'h1;
						st_d = S_ISSUE;
					end
					else if (b_write_q && op_q == OP_ID_ENTER)
					begin
						wr_done_d = 1'b1;
						id_mode_d = 1'b1;
						st_d = S_ISSUE;
					end
					else
					begin
						st_d = S_IDLE;
						rsp_v_d = 1'b1;
						rsp_data_d = b_write_q ? 8'h00 : b_rdata;
						rsp_id_d = !b_write_q && (id_mode_q || hv_line_nine_q);
						// Protection status codes are not identifier bytes and carry no parity
						rsp_perr_d = rsp_id_d && !addr_q[PROT_SEL_BIT] && !(^b_rdata);
						hv_line_nine_d = 1'b0;
						if (op_q == OP_RESET_CMD || op_q == OP_RESET_UNLOCK)
						begin
							id_mode_d = 1'b0;
						end
						if (op_q == OP_PROGRAM || op_q == OP_CHIP_ERASE || op_q == OP_SECTOR_ERASE)
						begin
							active_d = 1'b1;
							sv_op_d = op_q;
							sv_addr_d = addr_q;
							sv_data_d = data_q;
						end
					end
				end
			end
			default:
			begin
				st_d = S_IDLE;
			end
		endcase
		// Unprotect voltage only while reset stays released
		hv_rst_d = TEMP_UNPROTECT_I && rst_n_d;
		ready_d = (st_d == S_IDLE);
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			st_q <= S_RST_LOW;
			op_q <= OP_READ;
			sv_op_q <= OP_READ;
			addr_q <= '0;
			sv_addr_q <= '0;
			data_q <= '0;
			sv_data_q <= '0;
			cnt_q <= 8'h00;
			idx_q <= 3'h0;
			{wr_done_q, last_q, b_start_q, b_write_q} <= 4'h0;
			b_addr_q <= '0;
			b_wdata_q <= '0;
			{rst_n_q, hv_line_nine_q, hv_rst_q, id_mode_q, active_q, replay_q, ready_q} <= 7'h00;
			{rsp_v_q, rsp_id_q, rsp_perr_q} <= 3'h0;
			rsp_data_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			op_q <= op_d;
			sv_op_q <= sv_op_d;
			addr_q <= addr_d;
			sv_addr_q <= sv_addr_d;
			data_q <= data_d;
			sv_data_q <= sv_data_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			{wr_done_q, last_q, b_start_q, b_write_q} <= {wr_done_d, last_d, b_start_d, b_write_d};
			b_addr_q <= b_addr_d;
			b_wdata_q <= b_wdata_d;
			{rst_n_q, hv_line_nine_q, hv_rst_q, id_mode_q} <= {rst_n_d, hv_line_nine_d, hv_rst_d, id_mode_d};
			{active_q, replay_q, ready_q} <= {active_d, replay_d, ready_d};
			{rsp_v_q, rsp_id_q, rsp_perr_q} <= {rsp_v_d, rsp_id_d, rsp_perr_d};
			rsp_data_q <= rsp_data_d;
		end
	end

	pfmc_bus_cycle u_bus (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.start_i(b_start_q),
		.write_i(b_write_q),
		.addr_i(b_addr_q),
		.wdata_i(b_wdata_q),
		.done_o(b_done),
		.rdata_o(b_rdata),
		.ce_n_o(FLASH_CE_N_O),
		.oe_n_o(FLASH_OE_N_O),
		.we_n_o(FLASH_WE_N_O),
		.addr_o(FLASH_ADDR_O),
		.data_o(FLASH_DATA_O),
		.data_oe_o(FLASH_DATA_OE_O),
		.data_i(FLASH_DATA_I)
	);

	assign CMD_READY_O = ready_q;
	assign RESP_VALID_O = rsp_v_q;
	assign RESP_DATA_O = rsp_data_q;
	assign RESP_ID_O = rsp_id_q;
	assign RESP_PARITY_ERR_O = rsp_perr_q;
	assign OP_PENDING_O = active_q;
	assign FLASH_RESET_N_O = rst_n_q;
	assign HV_ADDRESS_LINE_NINE_EN_O = hv_line_nine_q;
	assign HV_RESET_EN_O = hv_rst_q;

	// ****************************************
	// Checks
	// ****************************************
	logic [7:0] low_len_q;
	always_ff @(posedge CORE_CLK_I)
	begin
		low_len_q <= (RST_I || rst_n_q) ? 8'h00 : low_len_q + 8'h01;
	end
	reset_width_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) $rose(rst_n_q) |-> $past(low_len_q) >= RST_LAST)
		else $error("flash reset released too early");
	reset_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) !rst_n_q |-> FLASH_CE_N_O && FLASH_WE_N_O)
		else $error("bus active during flash reset");
	hv_nine_read_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		hv_line_nine_q |-> FLASH_WE_N_O)
		else $error("write with high voltage on address nine");
	hv_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) hv_rst_q |-> rst_n_q)
		else $error("unprotect voltage while reset low");
	id_cleared_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) $fell(rst_n_q) |-> !id_mode_q)
		else $error("identifier mode survived hardware reset");
	answer_bound_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(CMD_VALID_I && ready_q && CMD_OP_I != OP_HW_RESET) |-> ##[2:120] rsp_v_q)
		else $error("command never answered");
	replay_start_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(st_q == S_RST_REC && replay_q && cnt_q == REC_LAST) |=> st_q == S_ISSUE && op_q == sv_op_q)
		else $error("interrupted operation not reissued");
	cov_program_c: cover property (@(posedge CORE_CLK_I) rsp_v_q && op_q == OP_PROGRAM);
	cov_sector_c: cover property (@(posedge CORE_CLK_I) rsp_v_q && op_q == OP_SECTOR_ERASE);
	cov_id_c: cover property (@(posedge CORE_CLK_I) rsp_v_q && rsp_id_q);
	cov_replay_c: cover property (@(posedge CORE_CLK_I) replay_q && $rose(rst_n_q));
endmodule

// ### sim/pfmc_flash_model.sv
// Behavioural model of the byte-wide flash device on the far side of pfmc_host.
// Assumes pin-level signals from the host; identifier values are arbitrary.
`timescale 1ns/1ns
module pfmc_flash_model
	import pfmc_pkg::*;
#(
	parameter logic [7:0] MID0 = 8'h2A,
	parameter logic [7:0] MID1 = 8'hC4,
	parameter logic [7:0] DID0 = 8'h51,
	parameter logic [7:0] DID1 = 8'h8F
)
(
	// Pins from the host
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic reset_n_i,
	input wire logic hv_line_nine_i,
	input wire logic hv_reset_i,
	input wire logic host_oe_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] data_i,
	// Pins to the host
	output logic [DATA_W-1:0] data_o
);
	// ****************************************
	// Command state
	// ****************************************
	logic [7:0] mem [logic [17:0]];
	logic [17:0] lat_a;
	logic [7:0] rd_val;
	logic [4:0] last_sec = 5'h00;
	logic id_mode = 1'b0;
	logic unprot;
	time t_low = 0;
	int step = 0;
	int prog_cnt = 0, chip_cnt = 0, sec_cnt = 0, susp_cnt = 0, res_cnt = 0, rst_cnt = 0, err_cnt = 0;
	wire wr_n = ce_n_i | we_n_i;
	wire drive = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
	assign unprot = hv_reset_i;
	always @*
		if (hv_line_nine_i || id_mode)
			rd_val = addr_i[1] ? 8'h00 : addr_i[0] ? (addr_i[8] ? DID1 : DID0) : (addr_i[8] ? MID1 : MID0);
		else
			rd_val = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
	// Released lines show a changing value, never the last byte
	assign data_o = drive ? rd_val : ~rd_val;
	always @(negedge oe_n_i)
		if (host_oe_i)
			err_cnt++;
	always @(negedge wr_n)
		lat_a = addr_i;
	always @(posedge wr_n)
		if (reset_n_i && oe_n_i)
			do_write(lat_a, data_i);
	always @(negedge reset_n_i)
	begin
		t_low = $time;
		step = 0;
		id_mode = 1'b0;
	end
	always @(posedge reset_n_i)
	begin
		rst_cnt++;
		if ($time - t_low < 500)
			err_cnt++;
	end
	task automatic do_write(input logic [17:0] a, input logic [7:0] d);
		logic u1;
		int nxt;
		u1 = (a == UNLOCK1_ADDR);
		nxt = 0;
		if (step != 0)
			id_mode = 1'b0;
		case (step)
			0: if (d == CMD_READ_RESET) id_mode = 1'b0;
				else if (d == CMD_SUSPEND) susp_cnt++;
				else if (d == CMD_RESUME) res_cnt++;
				else if (u1 && d == UNLOCK1_DATA) nxt = 1;
			1: if (a == UNLOCK2_ADDR && d == UNLOCK2_DATA) nxt = 2;
			2: if (u1 && d == CMD_IDENTIFY) id_mode = 1'b1;
				else if (u1 && d == CMD_PROGRAM) nxt = 3;
				else if (u1 && d == CMD_ERASE_SETUP) nxt = 4;
			3:
			begin
				mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & d;
				prog_cnt++;
			end
			4: if (u1 && d == UNLOCK1_DATA) nxt = 5;
			5: if (a == UNLOCK2_ADDR && d == UNLOCK2_DATA) nxt = 6;
			6: if (u1 && d == CMD_CHIP_ERASE)
				begin
					mem.delete();
					chip_cnt++;
				end
				else if (d == CMD_SECTOR_ERASE)
				begin
					last_sec = a[17:13];
					sec_cnt++;
					foreach (mem[k])
						if (k[17:13] == a[17:13])
							mem[k] = 8'hFF;
				end
			default: nxt = 0;
		endcase
		step = nxt;
	endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for pfmc_host against the flash model.
// Assumes a 50 MHz clock and registered host outputs.
`timescale 1ns/1ns
module tb_top
	import pfmc_pkg::*;
;
	// Arbitrary identifier bytes with odd parity, indexed by {address bit 8, address bit 0}
	localparam logic [7:0] IDS [4] = '{8'h2A, 8'h51, 8'hC4, 8'h8F};
	localparam logic [9:0] W = 10'h000;
	logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, op_done = 1'b0, temp_unprot = 1'b0;
	pfmc_op_t cmd_op = OP_READ;
	logic [17:0] cmd_addr = 18'h00000, a, b, faddr;
	logic [7:0] cmd_data = 8'h00, d, resp_data, fdata_o, fdata_i;
	logic ready, resp_valid, resp_id, perr, pending, ce_n, oe_n, we_n, reset_n, data_oe, hv_line_nine, hv_rst;
	logic [9:0] exp_q [$];
	logic [9:0] e_m;
	logic [31:0] seed = 32'h4ac0b535;
	int num_errors = 0, cmp_count = 0, n;
	always #10 clk = ~clk;
	pfmc_host pfmc_host_i (.CORE_CLK_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op),
		.CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data), .CMD_READY_O(ready), .OP_DONE_I(op_done),
		.TEMP_UNPROTECT_I(temp_unprot), .RESP_VALID_O(resp_valid), .RESP_DATA_O(resp_data), .RESP_ID_O(resp_id),
		.RESP_PARITY_ERR_O(perr), .OP_PENDING_O(pending), .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n),
		.FLASH_WE_N_O(we_n), .FLASH_RESET_N_O(reset_n), .FLASH_ADDR_O(faddr), .FLASH_DATA_O(fdata_o),
		.FLASH_DATA_OE_O(data_oe), .FLASH_DATA_I(fdata_i), .HV_ADDRESS_LINE_NINE_EN_O(hv_line_nine),
		.HV_RESET_EN_O(hv_rst));
	pfmc_flash_model #(.MID0(IDS[0]), .MID1(IDS[2]), .DID0(IDS[1]), .DID1(IDS[3])) pfmc_flash_model_i (
		.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(reset_n), .hv_line_nine_i(hv_line_nine),
		.hv_reset_i(hv_rst),
		.host_oe_i(data_oe), .addr_i(faddr), .data_i(fdata_o), .data_o(fdata_i));
	// ****************************************
	// Checking and closing
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic timeout;
		num_errors++;
		print_verdict;
	endtask
	// Expectation bits: [9] compare id flag and parity error flag (expected low), [8] id flag, [7:0] byte
	always @(posedge clk)
		if (resp_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000);
			else
			begin
				e_m = exp_q.pop_front();
				check({8'h00, resp_data}, {8'h00, e_m[7:0]});
				if (e_m[9])
					check({7'h00, resp_id, 7'h00, perr}, {7'h00, e_m[8], 8'h00});
			end
		end
	// ****************************************
	// Drivers
	// ****************************************
	task automatic issue(input pfmc_op_t op, input logic [17:0] ad, input logic [7:0] dt, input logic [9:0] e);
		int i;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = ad;
		cmd_data = dt;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (ready !== 1'b1 && i < 3000);
		exp_q.push_back(e);
		if (i >= 3000)
			timeout;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 3000 && exp_q.size() != 0; i++)
			@(posedge clk);
		if (exp_q.size() != 0)
			timeout;
		@(negedge clk);
	endtask
	task automatic pulse_done;
		@(negedge clk);
		op_done = 1'b1;
		@(negedge clk);
		op_done = 1'b0;
		check({15'h0000, pending}, 16'h0000);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		seed = xs(seed);
		a = seed[17:0];
		d = seed[31:24];
		issue(OP_READ, a, 8'h00, 10'h2FF);
		issue(OP_PROGRAM, a, d, W);
		check({15'h0000, pending}, 16'h0001);
		check(16'(pfmc_flash_model_i.prog_cnt), 16'h0001);
		pulse_done;
		issue(OP_READ, a, 8'h00, {2'b10, d});
		temp_unprot = 1'b1;
		repeat (3) @(negedge clk);
		check({15'h0000, hv_rst}, 16'h0001);
		temp_unprot = 1'b0;
		repeat (3) @(negedge clk);
		check({15'h0000, hv_rst}, 16'h0000);
		issue(OP_ID_ENTER, 18'h00000, 8'h00, {2'b11, IDS[0]});
		issue(OP_READ, 18'h00100, 8'h00, {2'b11, IDS[2]});
		issue(OP_READ, 18'h00101, 8'h00, {2'b11, IDS[3]});
		issue(OP_READ, 18'h20002, 8'h00, 10'h300);
		issue(OP_RESET_CMD, 18'h12345, 8'h00, W);
		issue(OP_READ, a, 8'h00, {2'b10, d});
		issue(OP_ID_ENTER, 18'h00001, 8'h00, {2'b11, IDS[1]});
		issue(OP_RESET_UNLOCK, 18'h00000, 8'h00, W);
		issue(OP_READ, a, 8'h00, {2'b10, d});
		for (n = 0; n < 4; n++)
			issue(OP_HW_ID_READ, {9'h000, n[1], 7'h00, n[0]}, 8'h00, {2'b11, IDS[n]});
		issue(OP_SUSPEND, a, 8'h00, W);
		issue(OP_RESUME, 18'h3FFFF, 8'h00, W);
		check(16'(pfmc_flash_model_i.susp_cnt * 16 + pfmc_flash_model_i.res_cnt), 16'h0011);
		issue(OP_CHIP_ERASE, 18'h00000, 8'h00, W);
		check(16'(pfmc_flash_model_i.chip_cnt), 16'h0001);
		pulse_done;
		issue(OP_READ, a, 8'h00, 10'h2FF);
		seed = xs(seed);
		b = seed[17:0];
		issue(OP_PROGRAM, b, seed[31:24] & 8'h7F, W);
		pulse_done;
		issue(OP_SECTOR_ERASE, b ^ 18'h01F0F, 8'h00, W);
		check({8'(pfmc_flash_model_i.sec_cnt), 3'h0, pfmc_flash_model_i.last_sec}, {8'h01, 3'h0, b[17:13]});
		pulse_done;
		issue(OP_READ, b, 8'h00, 10'h2FF);
		issue(OP_PROGRAM, a, 8'h5A, W);
		n = pfmc_flash_model_i.prog_cnt;
		// The replayed program answers once more after recovery
		exp_q.push_back(W);
		issue(OP_HW_RESET, 18'h00000, 8'h00, W);
		issue(OP_READ, a, 8'h00, 10'h25A);
		check(16'(pfmc_flash_model_i.prog_cnt), 16'(n + 1));
		check(16'(pfmc_flash_model_i.rst_cnt), 16'h0002);
		check(16'(pfmc_flash_model_i.err_cnt), 16'h0000);
		print_verdict;
	end
endmodule
